// File: fshp_pkg.sv
// Package of constants and types for the frame-store host I/O port
//
// Overview of operation
// - Address-device write latches outbus, then holds memory wait request until memory ready.
// - Data-device read strobe drives data buffer onto host input bus.
// - Data-device write: output strobe then transfer pulse captures outbus into data buffer.
// - Any output to the data device clears the read-direction flag.
// - Any output to the address device sets read direction once cycle executes.
// - Address write in read direction loads data buffer; in write direction stores it.
// - Host input from either device leaves read-direction flag unchanged.
// - After any completed read or write sequence, port rests in read direction.
// - Address-device tests: 0 int enabled, 1 power, 2 half-word, 3 read dir, 4 picture.
// - Data-device test 0 true with no camera; nonzero true when that camera selected.
// - Address-device controls: 0 int on, 1 int off, 2 half, 3 full, 4 read dir.
// - Data-device control 0 deselects cameras; nonzero selects that numbered camera.
// - Three-line camera select output follows the data-device control choice.
// - Full-word mode takes a 15-bit word address from the outbus.
// - Acknowledge output shows the port ready for the next host I/O operation.
// - Word mode moves both bytes with 15-bit address; byte mode uses 16-bit address.
// - Memory wait request blocks host instructions that could overwrite the data buffer.
package fshp_pkg;
   // ==========================================================
   // Widths and codes
   localparam int BUS_W = 16;
   localparam int CODE_W = 3;
   localparam int WADDR_W = 15;
   localparam logic [2:0] CODE_INT_ON = 3'h0;
   localparam logic [2:0] CODE_INT_OFF = 3'h1;
   localparam logic [2:0] CODE_HALF = 3'h2;
   localparam logic [2:0] CODE_FULL = 3'h3;
   localparam logic [2:0] CODE_READ_DIR = 3'h4;
   localparam logic [2:0] TEST_INT_EN = 3'h0;
   localparam logic [2:0] TEST_POWER = 3'h1;
   localparam logic [2:0] TEST_HALF = 3'h2;
   localparam logic [2:0] TEST_READ_DIR = 3'h3;
   localparam logic [2:0] TEST_PICTURE = 3'h4;
   localparam logic [2:0] CAM_NONE = 3'h0;
   // ==========================================================
   // Reset values
   localparam logic RST_READ_DIR = 1'b1;
   localparam logic RST_HALF_WORD = 1'b0;
   localparam logic RST_INT_EN = 1'b0;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Host strobes from the I/O bus, one bundle
   typedef struct packed {
      logic output_strobe;       // Host write strobe
      logic data_transfer_pulse; // Host transfer pulse
      logic read_strobe;         // Host read strobe
      logic test_strobe;         // Test instruction strobe
      logic control_strobe;      // Control instruction strobe
      logic sel_addr;            // Address device selected
      logic sel_data;            // Data device selected
      logic int_ack;             // Interrupt acknowledge
   } fshp_host_s;

   // Image memory request toward the arbiter
   typedef struct packed {
      logic [15:0] addr;         // Byte or word address
      logic [15:0] wdata;        // Write content
      logic write;               // 1 store, 0 fetch
      logic word;                // Full-word access
   } fshp_mem_s;
endpackage

// File: fshp_sync.sv
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module fshp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_core_clk,             // Core clock
   input wire logic i_rstn,                 // Async reset, active low
   input wire logic [WIDTH-1:0] i_async,    // Unsynchronised levels
   output logic [WIDTH-1:0] o_sync          // Synchronised levels
);
   import fshp_pkg::*;
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // ==========================================================
   // Flops only; first stage feeds nothing but the second
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;
endmodule

// File: fshp_port.sv
// Host programmed I/O port of the frame store: address and data devices
`timescale 1ns/1ps
module fshp_port #(
   parameter int NUM_CAMERAS = 7
) (
   input wire logic i_core_clk,                   // Core clock 200 MHz
   input wire logic i_rstn,                       // Async reset, active low
   input wire fshp_pkg::fshp_host_s i_host,       // Host strobes (pins)
   input wire logic [fshp_pkg::BUS_W-1:0] i_outbus, // Host output bus
   input wire logic [fshp_pkg::CODE_W-1:0] i_code, // Test/control code
   input wire logic i_power_on,                   // Power good pin
   input wire logic i_picture_done,               // Frame done pulse
   input wire logic i_mem_ready,                  // Memory served access
   input wire logic [fshp_pkg::BUS_W-1:0] i_mem_rdata, // Fetched content
   output logic [fshp_pkg::BUS_W-1:0] o_inbus,    // Host input bus
   output logic o_test_true,                      // Test result
   output logic o_memory_wait_request,            // Wait toward host
   output logic o_ack,                            // Ready for next I/O
   output logic o_int_req,                        // Interrupt request
   output logic [2:0] o_camera_select,            // Camera select lines
   output logic o_half_word_flag,                 // Half-word mode
   output logic o_read_direction_flag,            // Read direction
   output logic o_mem_req,                        // Memory access request
   output fshp_pkg::fshp_mem_s o_mem              // Memory access fields
);
   import fshp_pkg::*;

   // Only three select lines exist, so seven cameras at most
   if (NUM_CAMERAS < 1 || NUM_CAMERAS > 7) begin : g_bad_cameras
      $error("NUM_CAMERAS must be 1..7");
   end

   // ==========================================================
   // Pin synchronisation
   localparam int NPIN = 10;
   logic [NPIN-1:0] pin_s;
   fshp_host_s h;
   logic power_s;
   logic pic_s;

   fshp_sync #(.WIDTH(NPIN)) u_sync (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async({i_host, i_power_on, i_picture_done}),
      .o_sync(pin_s)
   );
   assign h = pin_s[NPIN-1:2];
   assign power_s = pin_s[1];
   assign pic_s = pin_s[0];

   // Bus and code take the same two flops as the strobes, so they
   // stand settled when the synchronised strobe edge is seen
   logic [BUS_W+CODE_W-1:0] bus_s;
   logic [BUS_W-1:0] outbus_s;
   logic [CODE_W-1:0] code_s;
   fshp_sync #(.WIDTH(BUS_W + CODE_W)) u_sync_bus (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async({i_outbus, i_code}),
      .o_sync(bus_s)
   );
   assign outbus_s = bus_s[BUS_W+CODE_W-1:CODE_W];
   assign code_s = bus_s[CODE_W-1:0];

   // ==========================================================
   // Edge detection on synchronised strobes
   fshp_host_s hprev_r;
   logic pic_prev_r;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hprev_r <= '0;
         pic_prev_r <= 1'b0;
      end else begin
         hprev_r <= h;
         pic_prev_r <= pic_s;
      end
   end

   logic dtp_rise, rd_rise, tst_rise, ctl_rise, iack_rise, pic_rise;
   logic addr_wr, data_wr, addr_ctl, data_ctl;
   assign dtp_rise = h.data_transfer_pulse & ~hprev_r.data_transfer_pulse;
   assign rd_rise = h.read_strobe & ~hprev_r.read_strobe;
   assign tst_rise = h.test_strobe & ~hprev_r.test_strobe;
   assign ctl_rise = h.control_strobe & ~hprev_r.control_strobe;
   assign iack_rise = h.int_ack & ~hprev_r.int_ack;
   assign pic_rise = pic_s & ~pic_prev_r;

   // Output cycle: strobe held, then transfer pulse edge
   logic busy;
   assign addr_wr = dtp_rise & h.output_strobe & h.sel_addr & ~busy;
   assign data_wr = dtp_rise & h.output_strobe & h.sel_data & ~busy;
   assign addr_ctl = ctl_rise & h.sel_addr & ~busy;
   assign data_ctl = ctl_rise & h.sel_data & ~busy;

   // ==========================================================
   // Access state machine
   typedef enum logic [0:0] {ST_IDLE, ST_WAIT} fshp_state_e;
   fshp_state_e state_r, state_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [15:0] data_r, data_nxt;
   logic rdir_r, rdir_nxt;
   logic cyc_write_r, cyc_write_nxt;
   logic half_r, half_nxt;
   logic inten_r, inten_nxt;
   logic pic_r, pic_nxt;
   logic irq_r, irq_nxt;
   logic [2:0] cam_r, cam_nxt;

   assign busy = (state_r == ST_WAIT);

   // Address shaping: word mode clears bit 15, keeping the low 15 bits
   function automatic logic [15:0] shape_addr(input logic [15:0] bus,
                                              input logic half);
      if (half)
         shape_addr = bus;
      else
         shape_addr = {1'b0, bus[WADDR_W-1:0]};
   endfunction

   // Next-state for all port state except the read path and test answer
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      rdir_nxt = rdir_r;
      cyc_write_nxt = cyc_write_r;
      half_nxt = half_r;
      inten_nxt = inten_r;
      pic_nxt = pic_r;
      irq_nxt = irq_r;
      cam_nxt = cam_r;
      case (state_r)
         ST_IDLE: begin
            if (data_wr) begin
               data_nxt = outbus_s;
               rdir_nxt = 1'b0;
            end else if (addr_wr) begin
               addr_nxt = shape_addr(outbus_s, half_r);
               cyc_write_nxt = ~rdir_r;
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (i_mem_ready) begin
               if (!cyc_write_r)
                  data_nxt = i_mem_rdata;
               rdir_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // Control codes; refused while access pending
      if (addr_ctl) begin
         case (code_s)
            CODE_INT_ON: inten_nxt = 1'b1;
            CODE_INT_OFF: inten_nxt = 1'b0;
            CODE_HALF: half_nxt = 1'b1;
            CODE_FULL: half_nxt = 1'b0;
            CODE_READ_DIR: rdir_nxt = 1'b1;
            default: ;
         endcase
      end
      if (data_ctl) begin
         if (code_s == CAM_NONE || 32'(code_s) <= NUM_CAMERAS)
            cam_nxt = code_s;
      end
      // Picture flag: set wins over acknowledge clear
      if (iack_rise) begin
         pic_nxt = 1'b0;
         irq_nxt = 1'b0;
      end
      if (pic_rise) begin
         pic_nxt = 1'b1;
         irq_nxt = inten_r;
      end
   end

   // Register all port state except the read path and test answer
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ST_IDLE;
         addr_r <= RST_WORD;
         data_r <= RST_WORD;
         rdir_r <= RST_READ_DIR;
         cyc_write_r <= 1'b0;
         half_r <= RST_HALF_WORD;
         inten_r <= RST_INT_EN;
         pic_r <= 1'b0;
         irq_r <= 1'b0;
         cam_r <= CAM_NONE;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         rdir_r <= rdir_nxt;
         cyc_write_r <= cyc_write_nxt;
         half_r <= half_nxt;
         inten_r <= inten_nxt;
         pic_r <= pic_nxt;
         irq_r <= irq_nxt;
         cam_r <= cam_nxt;
      end
   end

   // ==========================================================
   // Host-facing read path and test answers, registered
   logic [15:0] inbus_r, inbus_nxt;
   logic test_r, test_nxt;
   always_comb begin
      inbus_nxt = inbus_r;
      test_nxt = test_r;
      // Reads never touch the direction flag
      if (rd_rise && h.sel_data)
         inbus_nxt = data_r;
      else if (rd_rise && h.sel_addr)
         inbus_nxt = addr_r;
      if (tst_rise && h.sel_addr) begin
         case (code_s)
            TEST_INT_EN: test_nxt = inten_r;
            TEST_POWER: test_nxt = power_s;
            TEST_HALF: test_nxt = half_r;
            TEST_READ_DIR: test_nxt = rdir_r;
            TEST_PICTURE: test_nxt = pic_r;
            default: test_nxt = 1'b0;
         endcase
      end else if (tst_rise && h.sel_data) begin
         test_nxt = (cam_r == code_s);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         inbus_r <= RST_WORD;
         test_r <= 1'b0;
      end else begin
         inbus_r <= inbus_nxt;
         test_r <= test_nxt;
      end
   end

   // ==========================================================
   // Outputs; wait request holds the host off the data buffer
   assign o_inbus = inbus_r;
   assign o_test_true = test_r;
   assign o_memory_wait_request = busy;
   assign o_ack = ~busy;
   assign o_int_req = irq_r;
   assign o_camera_select = cam_r;
   assign o_half_word_flag = half_r;
   assign o_read_direction_flag = rdir_r;
   assign o_mem_req = busy;
   assign o_mem = '{addr: addr_r, wdata: data_r, write: cyc_write_r,
                    word: ~half_r};

   // ==========================================================
   // Assertions
   sequence s_addr_write;
      addr_wr;
   endsequence
   sequence s_served;
      busy && i_mem_ready;
   endsequence

   property p_wait_after_addr;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_addr_write |=> o_memory_wait_request;
   endproperty
   a_wait_after_addr: assert property (p_wait_after_addr)
      else $error("wait request not raised after address write");

   property p_wait_holds;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (busy && !i_mem_ready) |=> busy;
   endproperty
   a_wait_holds: assert property (p_wait_holds)
      else $error("wait request dropped before memory ready");

   property p_read_dir_after;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_served |=> (o_read_direction_flag && o_ack);
   endproperty
   a_read_dir_after: assert property (p_read_dir_after)
      else $error("not in read direction after access");

   property p_data_clears;
      @(posedge i_core_clk) disable iff (!i_rstn)
      data_wr |=> (!o_read_direction_flag && data_r == $past(outbus_s));
   endproperty
   a_data_clears: assert property (p_data_clears)
      else $error("data write did not clear direction or load buffer");

   property p_read_keeps;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (rd_rise && !busy && !data_wr && !addr_ctl)
         |=> $stable(o_read_direction_flag);
   endproperty
   a_read_keeps: assert property (p_read_keeps)
      else $error("read changed direction flag");

   property p_fetch_loads;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (s_served and !cyc_write_r) |=> data_r == $past(i_mem_rdata);
   endproperty
   a_fetch_loads: assert property (p_fetch_loads)
      else $error("fetch did not load data buffer");

   property p_ack_vs_wait;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (o_ack && !addr_wr) |=> o_ack;
   endproperty
   a_ack_vs_wait: assert property (p_ack_vs_wait)
      else $error("acknowledge dropped without an address write");

   property p_cam_none;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (data_ctl && code_s == CAM_NONE) |=> o_camera_select == 3'h0;
   endproperty
   a_cam_none: assert property (p_cam_none)
      else $error("camera not deselected");

   property p_word_addr;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (addr_wr && !half_r) |=> o_mem.addr[15] == 1'b0;
   endproperty
   a_word_addr: assert property (p_word_addr)
      else $error("word address wider than 15 bits");
endmodule

// File: fshp_host_model.sv
// Host CPU model driving the programmed I/O strobes of the port
`timescale 1ns/1ps
module fshp_host_model (
   input wire logic i_core_clk,                   // Core clock
   input wire logic i_ack,                        // Port ready for next I/O
   output fshp_pkg::fshp_host_s o_host,           // Host strobes
   output logic [fshp_pkg::BUS_W-1:0] o_outbus,   // Host output bus
   output logic [fshp_pkg::CODE_W-1:0] o_code     // Test/control code
);
   import fshp_pkg::*;
   // Cleared only to push instructions into a busy port on purpose
   logic polite = 1'b1;

   initial begin
      o_host = '0;
      o_outbus = 16'h0000;
      o_code = 3'h0;
   end

   // ====================
   // Strobe bundle for one device
   function automatic fshp_host_s mk(input logic [4:0] s, input logic a);
      fshp_host_s h;
      h = '0;
      {h.output_strobe, h.data_transfer_pulse, h.read_strobe,
       h.test_strobe, h.control_strobe} = s;
      h.sel_addr = a;
      h.sel_data = !a;
      return h;
   endfunction

   // ====================
   // One instruction: wait, select, strobe, hold, release
   task automatic op(input fshp_host_s h, input logic [15:0] d,
                     input logic [2:0] c);
      fshp_host_s first;
      int n;
      first = h;
      first.data_transfer_pulse = 1'b0;
      n = 0;
      while (polite && i_ack !== 1'b1 && n < 400) begin
         @(posedge i_core_clk);
         n++;
      end
      @(posedge i_core_clk);
      o_outbus <= d;
      o_code <= c;
      o_host <= first;
      @(posedge i_core_clk);
      o_host <= h; // Pulse only after the strobe
      repeat (6) @(posedge i_core_clk);
      o_host <= '0;
      // Released bus must not look like a held value
      o_outbus <= ~d;
      o_code <= ~c;
      repeat (6) @(posedge i_core_clk);
   endtask

   task automatic wr(input logic a, input logic [15:0] d);
      op(mk(5'b11000, a), d, 3'h0);
   endtask
   task automatic rd(input logic a);
      op(mk(5'b00100, a), 16'h0000, 3'h0);
   endtask
   task automatic tst(input logic a, input logic [2:0] c);
      op(mk(5'b00010, a), 16'h0000, c);
   endtask
   task automatic ctl(input logic a, input logic [2:0] c);
      op(mk(5'b00001, a), 16'h0000, c);
   endtask
   task automatic iack();
      fshp_host_s h;
      h = '0;
      h.int_ack = 1'b1;
      op(h, 16'h0000, 3'h0);
   endtask
endmodule

// File: tb_fshp_port.sv
// Self-checking bench for the frame-store host I/O port
`timescale 1ns/1ps
module tb_fshp_port;
   import fshp_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   fshp_host_s host;
   logic [15:0] outbus, inbus, last_rdata;
   logic [2:0] code, cam;
   logic power_on = 1'b1;
   logic picture_done = 1'b0;
   logic mem_ready = 1'b0;
   logic [15:0] mem_rdata = 16'h0000;
   logic test_true, wait_req, ack, int_req, half, rdir, mem_req, hw;
   fshp_mem_s mem, last_mem;
   logic [31:0] seed = 32'h54e1_8775;
   logic [31:0] mseed = 32'h54e1_8775;
   logic stall = 1'b0;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_acc = 0;
   int mcnt = 0;
   int cyc = 0;

   always #2.5 clk = ~clk;

   fshp_port #(.NUM_CAMERAS(7)) fshp_port_i (.i_core_clk(clk),
      .i_rstn(rstn), .i_host(host), .i_outbus(outbus), .i_code(code),
      .i_power_on(power_on), .i_picture_done(picture_done),
      .i_mem_ready(mem_ready), .i_mem_rdata(mem_rdata), .o_inbus(inbus),
      .o_test_true(test_true), .o_memory_wait_request(wait_req),
      .o_ack(ack), .o_int_req(int_req), .o_camera_select(cam),
      .o_half_word_flag(half), .o_read_direction_flag(rdir),
      .o_mem_req(mem_req), .o_mem(mem));
   fshp_host_model fshp_host_model_i (.i_core_clk(clk), .i_ack(ack),
      .o_host(host), .o_outbus(outbus), .o_code(code));

   // ====================
   // Expectation helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_addr(input logic [15:0] x,
                                            input logic h);
      return h ? x : {1'b0, x[14:0]};
   endfunction
   function automatic logic exp_atest(input logic [2:0] c,
      input logic ie, input logic pw, input logic h, input logic rd);
      logic [7:0] v;
      v = {4'h0, rd, h, pw, ie};
      return v[c];
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_end(input string s);
      $display("test %s finished", s);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ====================
   // Image memory side: random latency, stall on demand
   always @(posedge clk) begin
      mseed <= lfsr_next(mseed);
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mcnt <= (mem_req === 1'b1) ? mcnt + 1 : 0;
      if (mem_req === 1'b1 && !stall && !mem_ready &&
          mcnt >= int'(mseed[1:0])) begin
         mem_ready <= 1'b1;
         mem_rdata <= mseed[31:16];
         last_rdata <= mseed[31:16];
         last_mem <= mem;
         n_acc <= n_acc + 1;
      end
   end

   // Hang guard, far above the expected few thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic wait_done();
      int n;
      n = 0;
      while (ack !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
   endtask

   task automatic pulse_pic();
      @(posedge clk);
      picture_done <= 1'b1;
      repeat (6) @(posedge clk);
      picture_done <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task automatic store(input logic [15:0] ad, input logic [15:0] dt,
                        input logic h);
      int k;
      fshp_host_model_i.wr(1'b0, dt); // Content first
      check(rdir, 1'b0);
      k = n_acc;
      fshp_host_model_i.wr(1'b1, ad); // Address second
      wait_done();
      check(16'(n_acc - k), 16'h0001);
      check(last_mem.write, 1'b1);
      check(last_mem.wdata, dt);
      check(last_mem.addr, exp_addr(ad, h));
      check(last_mem.word, !h);
      check(rdir, 1'b1);
   endtask

   task automatic fetch(input logic [15:0] ad, input logic h);
      int k;
      k = n_acc;
      fshp_host_model_i.wr(1'b1, ad); // Address first
      wait_done();
      check(16'(n_acc - k), 16'h0001);
      check(last_mem.write, 1'b0);
      check(last_mem.addr, exp_addr(ad, h));
      fshp_host_model_i.rd(1'b0); // Data read second
      check(inbus, last_rdata);
      check(rdir, 1'b1);
   endtask

   // ====================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check(ack, 1'b1);
      check(wait_req, 1'b0);
      check(rdir, RST_READ_DIR);
      check(cam, CAM_NONE);
      check(int_req, 1'b0);
      test_end("reset");
      hw = 1'b0;
      store(16'hffff, 16'h0000, 1'b0);
      fetch(16'h8000, 1'b0);
      store(16'h0000, 16'hffff, 1'b0);
      test_end("corners");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr_next(seed);
         hw = seed[0];
         fshp_host_model_i.ctl(1'b1, hw ? CODE_HALF : CODE_FULL);
         check(half, hw);
         store(seed[31:16], seed[15:0] ^ 16'h5a5a, hw);
         fetch(seed[15:0], hw);
      end
      test_end("random");
      fshp_host_model_i.wr(1'b0, 16'h1234);
      fshp_host_model_i.rd(1'b0);
      check(inbus, 16'h1234);
      fshp_host_model_i.rd(1'b1);
      check(rdir, 1'b0);
      // Store abandoned, so direction is restored by hand
      fshp_host_model_i.ctl(1'b1, CODE_READ_DIR);
      check(rdir, 1'b1);
      test_end("direction");
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         power_on <= !p[0];
         fshp_host_model_i.ctl(1'b1, p[0] ? CODE_INT_ON : CODE_INT_OFF);
         for (int c = 0; c < 6; c++) begin
            fshp_host_model_i.tst(1'b1, c[2:0]);
            check(test_true, exp_atest(c[2:0], p[0], !p[0], hw, 1'b1));
         end
      end
      test_end("address tests");
      fshp_host_model_i.ctl(1'b1, CODE_INT_ON);
      pulse_pic();
      check(int_req, 1'b1);
      fshp_host_model_i.tst(1'b1, TEST_PICTURE);
      check(test_true, 1'b1);
      fshp_host_model_i.iack();
      check(int_req, 1'b0);
      fshp_host_model_i.ctl(1'b1, CODE_INT_OFF);
      pulse_pic();
      check(int_req, 1'b0);
      fshp_host_model_i.iack();
      test_end("interrupt");
      for (int c = 0; c < 8; c++) begin
         fshp_host_model_i.ctl(1'b0, c[2:0]);
         check(cam, c[2:0]);
         fshp_host_model_i.tst(1'b0, c[2:0]);
         check(test_true, 1'b1);
         fshp_host_model_i.tst(1'b0, 3'(c + 1));
         check(test_true, 1'b0);
      end
      test_end("cameras");
      stall <= 1'b1;
      fshp_host_model_i.wr(1'b0, 16'hc3a5);
      fshp_host_model_i.wr(1'b1, 16'h0042);
      check(wait_req, 1'b1);
      check(mem_req, 1'b1);
      check(ack, 1'b0);
      fshp_host_model_i.polite = 1'b0;
      fshp_host_model_i.wr(1'b0, 16'h3c5a);
      fshp_host_model_i.ctl(1'b0, CAM_NONE);
      fshp_host_model_i.polite = 1'b1;
      check(wait_req, 1'b1);
      stall <= 1'b0;
      wait_done();
      check(last_mem.wdata, 16'hc3a5);
      check(cam, 3'h7);
      test_end("busy");
      results();
   end
endmodule
